//--- design/mpsd_defines.vh
// mpsd_defines.vh: constants for the mains power switch driver.
// assumes inclusion by bare name from design files only.
`ifndef MPSD_DEFINES_VH
`define MPSD_DEFINES_VH

// driver control register field positions
`define MPSD_CTL_POL_BIT 0
`define MPSD_CTL_MODE_LO 2
`define MPSD_CTL_MODE_HI 3
`define MPSD_CTL_CLOCK_SOURCE_SELECT_BIT 4
`define MPSD_CTL_RUN_BIT 5
`define MPSD_CTL_MERGE_BIT 6
`define MPSD_CTL_SET_BIT 7
// interrupt config register field positions
`define MPSD_INT_SEL_LO 3
`define MPSD_INT_SEL_HI 5
// modes
`define MPSD_MODE_PWM 2'h0
`define MPSD_MODE_BURST 2'h1
// interrupt select codes (bits 4:3 of the field): bit 4 unmasks rise, bit 3 fall
`define MPSD_INT_NONE 2'h0
`define MPSD_INT_RISE 2'h2
`define MPSD_INT_FALL 2'h1
`define MPSD_INT_BOTH 2'h3
// last count of the period in prescaled ticks
`define MPSD_PERIOD_LAST 8'hfe
`define MPSD_DUTY_FULL 8'hff
// reset values
`define MPSD_CTL_RESET 8'h00
`define MPSD_CNT_RESET 8'h00

`endif

//--- design/mpsd_sync.v
// mpsd_sync.v: two-flop synchroniser with rising/falling edge pulses.
// assumes an asynchronous pin input and one system clock.
`timescale 1ns/100ps
`default_nettype none
module mpsd_sync (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_pin,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_r;
  reg sync_r;
  reg last_r;
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign o_level = sync_r;
  assign o_rise = sync_r & ~last_r;
  assign o_fall = ~sync_r & last_r;
endmodule
`default_nettype wire

//--- design/mpsd_top.v
// mpsd_top.v: mains power switch driver, pwm and burst modes.
// assumes control bits held by the processor as plain ports, one clock.
`timescale 1ns/100ps
`default_nettype none
`include "mpsd_defines.vh"
module mpsd_top #(
  parameter PRESC_W = 16,
  parameter WIDTH_W = 16
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [7:0] i_driver_control_reg,
  input wire [7:0] i_prescaler_low_reg,
  input wire [7:0] i_prescaler_high_reg,
  input wire [7:0] i_duty_value_reg,
  input wire [7:0] i_interrupt_config_reg,
  input wire [WIDTH_W-1:0] i_pulse_width,
  input wire i_mains_sync_a,
  input wire i_mains_sync_b,
  output reg o_power_switch_output,
  output reg o_power_switch_oe_n,
  output reg o_int_rise,
  output reg o_int_fall,
  output reg [7:0] o_count
);
  ////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_HOLD = 3'b100;

  wire driver_set_bit = i_driver_control_reg[`MPSD_CTL_SET_BIT];
  wire counter_run_bit = i_driver_control_reg[`MPSD_CTL_RUN_BIT];
  wire clock_source_select = i_driver_control_reg[`MPSD_CTL_CLOCK_SOURCE_SELECT_BIT];
  wire merge_b = i_driver_control_reg[`MPSD_CTL_MERGE_BIT];
  wire pol = i_driver_control_reg[`MPSD_CTL_POL_BIT];
  wire [1:0] mode = i_driver_control_reg[`MPSD_CTL_MODE_HI:`MPSD_CTL_MODE_LO];
  wire [1:0] interrupt_select = i_interrupt_config_reg[`MPSD_INT_SEL_HI-1:`MPSD_INT_SEL_LO];
  wire [PRESC_W-1:0] presc_n = {i_prescaler_high_reg, i_prescaler_low_reg};

  wire a_lvl, a_rise, a_fall;
  wire b_lvl, b_rise, b_fall;
  mpsd_sync u_sync_a (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_mains_sync_a),
    .o_level(a_lvl),
    .o_rise(a_rise),
    .o_fall(a_fall)
  );
  mpsd_sync u_sync_b (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_mains_sync_b),
    .o_level(b_lvl),
    .o_rise(b_rise),
    .o_fall(b_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // prescaler input: every master cycle, or each mains a rising edge
  wire src_tick = clock_source_select ? a_rise : 1'b1;
  wire is_pwm = (mode == `MPSD_MODE_PWM);
  wire is_burst = (mode == `MPSD_MODE_BURST);
  wire active = driver_set_bit & counter_run_bit & ~mode[1];

  reg [2:0] state_r;
  reg [PRESC_W-1:0] presc_r;
  reg [7:0] cnt_r;
  reg [7:0] duty_r;
  reg tb_r;
  reg first_r;
  reg [WIDTH_W-1:0] pw_cnt_r;
  reg pulse_r;

  // >= so a prescaler value lowered mid-count cannot stall a full 16-bit wrap
  wire tick = active & src_tick & (presc_r >= presc_n);
  wire wrap = tick & (cnt_r == `MPSD_PERIOD_LAST);

  function tb_level;
    input [7:0] c;
    input [7:0] d;
    begin
      tb_level = (d == `MPSD_DUTY_FULL) | (c < d);
    end
  endfunction

  wire [7:0] cnt_nxt = wrap ? `MPSD_CNT_RESET : cnt_r + 8'h01;
  wire tb_nxt = tb_level(tick ? cnt_nxt : cnt_r, wrap ? i_duty_value_reg : duty_r);

  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (!i_reset_n || !driver_set_bit) begin
      state_r <= ST_IDLE;
      presc_r <= {PRESC_W{1'b0}};
      cnt_r <= `MPSD_CNT_RESET;
      duty_r <= 8'h00;
      tb_r <= 1'b0;
      first_r <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (active) begin
            state_r <= ST_RUN;
            duty_r <= i_duty_value_reg;
          end
        end
        ST_RUN: begin
          if (!active) begin
            state_r <= ST_HOLD;
          end
          if (active & src_tick) begin
            presc_r <= tick ? {PRESC_W{1'b0}} : presc_r + 1'b1;
          end
          if (tick) begin
            cnt_r <= cnt_nxt;
          end
          if (wrap) begin
            duty_r <= i_duty_value_reg;
            first_r <= 1'b0;
          end
          if (state_r == ST_RUN && active) begin
            tb_r <= tb_nxt;
          end
        end
        ST_HOLD: begin
          if (active) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupts from period signal edges; first period suppressed
  wire tb_edge_r = ~tb_r & tb_nxt;
  wire tb_edge_f = tb_r & ~tb_nxt;
  wire run_now = (state_r == ST_RUN) & active;
  // duty 0 or 255 has no edges: both pulse together at each wrap
  wire flat = (duty_r == 8'h00) | (duty_r == `MPSD_DUTY_FULL);
  // the start edge is dropped, the edge at the first wrap is one period in
  wire ev_r = run_now & (flat ? wrap : (tb_edge_r & (~first_r | wrap)));
  wire ev_f = run_now & (flat ? wrap : (tb_edge_f & ~first_r));

  always @(posedge i_clk) begin
    if (!i_reset_n || !driver_set_bit) begin
      o_int_rise <= 1'b0;
      o_int_fall <= 1'b0;
    end else begin
      // one master clock cycle each
      o_int_rise <= ev_r & interrupt_select[1];
      o_int_fall <= ev_f & interrupt_select[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // burst: pulse on mains a rising and mains b falling (mains a falling if merge_b is set) while tb high
  wire b_fall_eff = merge_b ? a_fall : b_fall;
  wire zc = a_rise | b_fall_eff;
  wire fire = is_burst & run_now & tb_r & zc;

  always @(posedge i_clk) begin
    if (!i_reset_n || !driver_set_bit) begin
      pw_cnt_r <= {WIDTH_W{1'b0}};
      pulse_r <= 1'b0;
    end else if (fire && i_pulse_width != {WIDTH_W{1'b0}}) begin
      pw_cnt_r <= i_pulse_width - 1'b1;
      pulse_r <= 1'b1;
    end else if (pw_cnt_r != {WIDTH_W{1'b0}}) begin
      pw_cnt_r <= pw_cnt_r - 1'b1;
    end else begin
      pulse_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_power_switch_output <= 1'b0;
      o_power_switch_oe_n <= 1'b1;
      o_count <= 8'h00;
    end else begin
      o_power_switch_oe_n <= ~driver_set_bit;
      o_count <= cnt_r;
      if (!driver_set_bit) begin
        o_power_switch_output <= 1'b0;
      end else if (is_pwm) begin
        o_power_switch_output <= tb_r;
      end else if (is_burst) begin
        o_power_switch_output <= pulse_r ^ pol;
      end else begin
        o_power_switch_output <= pol;
      end
    end
  end

  // unused level outputs and mains b rise pulse of the synchronisers
  wire unused_ok = a_lvl ^ b_lvl ^ b_rise;
endmodule
`default_nettype wire

//--- dv/mpsd_mains_model.sv
// mpsd_mains_model.sv: zero-crossing circuit feeding both sync pins.
// assumes a 50 percent mains wave of 20 master cycles, unrelated phase.
`timescale 1ns/100ps
`default_nettype none
module mpsd_mains_model #(
  parameter int HALF_NS = 100
) (
  output var logic o_sync_a,
  output wire logic o_sync_b
);
  // far below half the master rate
  initial begin
    o_sync_a = 1'b0;
    #3;
    forever begin
      #HALF_NS o_sync_a = ~o_sync_a;
    end
  end
  // a rises at one crossing, b falls at the next
  assign o_sync_b = o_sync_a;
endmodule
`default_nettype wire

//--- dv/mpsd_checker.sv
// mpsd_checker.sv: temporal checks on the switch driver ports.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module mpsd_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_driver_control_reg,
  input wire logic [7:0] i_interrupt_config_reg,
  input wire logic o_power_switch_output,
  input wire logic o_power_switch_oe_n,
  input wire logic o_int_rise,
  input wire logic o_int_fall,
  input wire logic [7:0] o_count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic en = i_driver_control_reg[7];
  wire logic run = i_driver_control_reg[5];
  wire logic [1:0] sel = i_interrupt_config_reg[4:3];
  a_hiz_when_clear: assert property (!en |=> o_power_switch_oe_n)
    else $error("switch driven while cleared");
  a_count_clear: assert property ((!en)[*3] |-> o_count == 8'h00)
    else $error("count kept while cleared");
  a_count_hold: assert property ((en && !run)[*3] |-> $stable(o_count))
    else $error("count moved while stopped");
  a_count_limit: assert property (o_count <= 8'hfe)
    else $error("count beyond period end");
  a_rise_pulse: assert property (o_int_rise |=> !o_int_rise)
    else $error("rise interrupt too long");
  a_fall_pulse: assert property ($rose(o_int_fall) |=> $fell(o_int_fall))
    else $error("fall interrupt too long");
  a_int_none: assert property ((sel == 2'h0)[*4] |-> !(o_int_rise || o_int_fall))
    else $error("interrupt while none selected");
  a_rise_only: assert property ((sel == 2'h2)[*4] |-> !o_int_fall)
    else $error("fall interrupt while rise selected");
  a_phase_idle: assert property ((en && i_driver_control_reg[3] &&
    $stable(i_driver_control_reg[0]))[*4] |-> o_power_switch_output == i_driver_control_reg[0])
    else $error("phase mode output not idle");
  cover property (o_int_rise && o_int_fall);
  cover property (o_power_switch_output && i_driver_control_reg[3:2] == 2'h1);
  cover property ($fell(o_power_switch_oe_n));
endmodule
bind mpsd_top mpsd_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_driver_control_reg(i_driver_control_reg), .i_interrupt_config_reg(i_interrupt_config_reg),
  .o_power_switch_output(o_power_switch_output), .o_power_switch_oe_n(o_power_switch_oe_n),
  .o_int_rise(o_int_rise), .o_int_fall(o_int_fall), .o_count(o_count));
`default_nettype wire

//--- dv/mpsd_top_bench.sv
// mpsd_top_bench.sv: self-checking bench for the switch driver.
// assumes the mains model on both sync pins, 100 MHz master clock.
`timescale 1ns/100ps
`default_nettype none
module mpsd_top_bench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] ctl = 8'h00, duty = 8'h00, icfg = 8'h00, plo = 8'h00;
  logic [15:0] pw = 16'h0004;
  wire logic sa, sb, out, oe_n, irise, ifall;
  wire logic [7:0] cnt;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc, hi, edg;
  always #5 i_clk = ~i_clk;
  mpsd_mains_model mains (.o_sync_a(sa), .o_sync_b(sb));
  mpsd_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_driver_control_reg(ctl),
    .i_prescaler_low_reg(plo), .i_prescaler_high_reg(8'h00), .i_duty_value_reg(duty),
    .i_interrupt_config_reg(icfg), .i_pulse_width(pw), .i_mains_sync_a(sa),
    .i_mains_sync_b(sb), .o_power_switch_output(out), .o_power_switch_oe_n(oe_n),
    .o_int_rise(irise), .o_int_fall(ifall), .o_count(cnt));
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // outputs read at the edge still hold their settled pre-edge values
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one period measured between rise interrupts; bounded so a dead run ends
  task automatic span;
    int n;
    logic last;
    cyc = 0;
    hi = 0;
    edg = 0;
    for (n = 0; n < 12000 && irise !== 1'b1; n++) step(1);
    if (n >= 12000) begin
      fail_count++;
      final_report;
    end
    last = out;
    do begin
      step(1);
      cyc++;
      hi += (out === 1'b1);
      edg += (out === 1'b1 && last === 1'b0);
      last = out;
    end while (irise !== 1'b1 && cyc < 12000);
    if (cyc >= 12000) begin
      fail_count++;
      final_report;
    end
  endtask
  task automatic t_hiz;
    ctl <= 8'h00;
    step(4);
    chk(oe_n, 1);
    ctl <= 8'h80;
    step(3);
    chk(oe_n, 0);
    $display("test hiz done");
  endtask
  task automatic t_pwm;
    int n;
    plo <= 8'h01;
    duty <= 8'h10;
    icfg <= 8'h10;
    ctl <= 8'h00;
    step(2);
    ctl <= 8'ha0;
    for (n = 0; n < 600 && irise !== 1'b1; n++) step(1);
    chk(n >= 510 && n <= 520, 1);
    if (n >= 600) final_report;
    span;
    chk(cyc, 255 * 2);
    chk(hi, 16 * 2);
    duty <= 8'h40;
    span;
    chk(hi, 16 * 2);
    span;
    chk(hi, 64 * 2);
    duty <= 8'hff;
    icfg <= 8'h18;
    span;
    span;
    chk(hi, cyc);
    chk(ifall, 1);
    $display("test pwm done");
  endtask
  task automatic t_pause;
    logic [7:0] c0;
    icfg <= 8'h10;
    ctl <= 8'h80;
    step(4);
    c0 = cnt;
    step(20);
    chk(cnt, c0);
    ctl <= 8'ha0;
    step(6);
    chk(cnt == c0, 0);
    ctl <= 8'h89;
    step(6);
    chk(out, 1);
    ctl <= 8'h8c;
    step(6);
    chk(out, 0);
    $display("test pause done");
  endtask
  task automatic t_burst;
    plo <= 8'h00;
    duty <= 8'h03;
    icfg <= 8'h10;
    ctl <= 8'hb4;
    span;
    span;
    chk(cyc, 255 * 20);
    chk(edg, 6);
    chk(hi, 6 * 4);
    ctl <= 8'hb5;
    // first period after the change still carries one sample at the old polarity
    span;
    span;
    chk(hi, 255 * 20 - 6 * 4);
    $display("test burst done");
  endtask
  initial begin
    step(3);
    i_reset_n <= 1'b1;
    t_hiz;
    t_pwm;
    t_pause;
    t_burst;
    final_report;
  end
endmodule
`default_nettype wire
